/* tb/sse_host_model.sv */
`timescale 1ns/1ps
module sse_host_model
  import sse_pkg::*;
(
  // Clock.
  input  wire logic                  clk,
  // Avalon-MM master side.
  output logic      [ADDR_WIDTH-1:0] avs_address,
  output logic                       avs_read,
  output logic                       avs_write,
  output logic      [BUS_WIDTH-1:0]  avs_writedata,
  output logic      [3:0]            avs_byteenable,
  input  wire logic [BUS_WIDTH-1:0]  avs_readdata,
  input  wire logic                  avs_waitrequest
);
  // The bus rests idle with no request until the bench asks for one.
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
  end

  // Builds an entry word; the host must put the entry's own code in the select field.
  function automatic logic [15:0] make_word(input logic [1:0] slot, input logic dir, input logic ret,
                                            input logic [3:0] chb, input logic [3:0] cha);
    make_word = {dir, 6'h28 | {4'h0, slot}, ret, chb, cha};
  endfunction

  // One transfer, held until waitrequest is seen low; only the bench watchdog ends a hang.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {16'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb
  import sse_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  resetn;
  logic                  convStart;
  logic                  convDone;
  logic [ADDR_WIDTH-1:0] avsAddress;
  logic                  avsRead;
  logic                  avsWrite;
  logic [BUS_WIDTH-1:0]  avsWritedata;
  logic [3:0]            avsByteenable;
  logic [BUS_WIDTH-1:0]  avsReaddata;
  logic                  avsWaitrequest;
  logic [CHAN_WIDTH-1:0] chanA;
  logic [CHAN_WIDTH-1:0] chanB;
  logic [SLOT_WIDTH-1:0] activeSlot;
  logic                  convBusy;
  logic [15:0]           w [4];
  logic [1:0]            es;
  logic [31:0]           rd;
  int                    badCount = 0;
  int                    samplesChecked = 0;

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  sse_top sse_top_inst (.clk(clk), .resetn(resetn), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .convStart(convStart),
    .convDone(convDone), .firstConverterChannel(chanA), .secondConverterChannel(chanB),
    .activeSlot(activeSlot), .convBusy(convBusy));

  sse_host_model host_inst (.clk(clk), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Starts a conversion and checks that the active entry's channels were latched.
  task automatic fire();
    convStart <= 1'b1;
    @(posedge clk);
    convStart <= 1'b0;
    @(posedge clk);
    chk("busy", 32'h1, {31'h0, convBusy});
    chk("chanA", {28'h0, w[es][3:0]}, {28'h0, chanA});
    chk("chanB", {28'h0, w[es][7:4]}, {28'h0, chanB});
  endtask

  // Ends a conversion; the next slot follows from the return flag, then a new one starts.
  task automatic advance();
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    @(posedge clk);
    es = w[es][8] ? 2'h0 : es + 2'h1;
    chk("slot", {30'h0, es}, {30'h0, activeSlot});
    chk("idle", 32'h0, {31'h0, convBusy});
    fire();
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    resetn    = 1'b0;
    convStart = 1'b0;
    convDone  = 1'b0;
    void'($urandom(43));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int s = 0; s < 4; s++) begin
      host_inst.acc(1'b0, 8'(8'ha0 + 4 * s), 16'h0, 4'hf, rd);
      chk("resetval", 32'(16'h5000 + 16'h200 * s), rd);
    end
    host_inst.acc(1'b0, 8'h00, 16'h0, 4'hf, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset_values done");
    for (int s = 0; s < 4; s++) begin
      w[s] = host_inst.make_word(2'(s), 1'($urandom), s == 3, 4'($urandom), 4'($urandom));
      host_inst.acc(1'b1, 8'(8'ha0 + 4 * s), w[s], 4'hf, rd);
      host_inst.acc(1'b0, 8'(8'ha0 + 4 * s), 16'h0, 4'hf, rd);
      chk("readback", {16'h0, w[s]}, rd);
    end
    host_inst.acc(1'b1, 8'ha4, w[1] ^ 16'h0200, 4'hf, rd);
    host_inst.acc(1'b0, 8'ha4, 16'h0, 4'hf, rd);
    chk("badcode", {16'h0, w[1]}, rd);
    es = 2'($urandom);
    host_inst.acc(1'b1, 8'ha8, {14'h0, es}, 4'h1, rd);
    w[2] = {w[2][15:8], 6'h0, es};
    host_inst.acc(1'b0, 8'ha8, 16'h0, 4'hf, rd);
    chk("lane", {16'h0, w[2]}, rd);
    $display("test entry_access done");
    es = 2'h0;
    chk("slot0", 32'h0, {30'h0, activeSlot});
    fire();
    repeat (6) advance();
    $display("test sequencing done");
    host_inst.acc(1'b0, 8'hc0, 16'h0, 4'hf, rd);
    chk("status", {19'h0, 1'b1, w[es][7:4], w[es][3:0], 2'h0, es}, rd);
    $display("test status_read done");
    // The edited entry also gets its return flag, so the walk must leave it for slot zero, not the next slot.
    w[es] = host_inst.make_word(es, 1'b0, 1'b1, ~w[es][7:4], ~w[es][3:0]);
    host_inst.acc(1'b1, 8'(8'ha0 + 4 * es), w[es], 4'hf, rd);
    chk("holdA", {28'h0, ~w[es][3:0]}, {28'h0, chanA});
    fire();
    advance();
    $display("test live_edit done");
    report_and_stop();
  end
endmodule

/* verilog/sse_entry_mem.sv */
`timescale 1ns/1ps
module sse_entry_mem
  import sse_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Store ports.
  sse_mem_if.mem   port
);

  logic [WORD_WIDTH-1:0] word_q [ENTRY_COUNT];
  logic [WORD_WIDTH-1:0] busRdata_q;
  logic [WORD_WIDTH-1:0] seqRdata_q;
  logic                  firstCycle_q;

  // Each entry resets to its own word and takes bus writes aimed at it.
  for (genvar g = 0; g < ENTRY_COUNT; g++) begin : gEntry
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        word_q[g] <= sse_reset_word(2'(g));
      end else if (port.busWe && port.busAddr == 2'(g)) begin
        word_q[g] <= port.busWdata;
      end
    end

    chk_sel_field_fixed: assert property (@(posedge clk) disable iff (!resetn)
      word_q[g][SEL_MSB:SEL_LSB] == sse_slot_code(2'(g)))
      else $error("Entry select field differs from its own code.");
  end

  // Both read ports come out of registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busRdata_q <= '0;
      seqRdata_q <= '0;
    end else begin
      busRdata_q <= word_q[port.busAddr];
      seqRdata_q <= word_q[port.seqAddr];
    end
  end

  assign port.busRdata = busRdata_q;
  assign port.seqRdata = seqRdata_q;

  // Marks the first cycle after reset release for the reset checks.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      firstCycle_q <= 1'b1;
    end else begin
      firstCycle_q <= 1'b0;
    end
  end

  chk_dir_bit_kept: assert property (@(posedge clk) disable iff (!resetn)
    port.busWe |=> word_q[$past(port.busAddr)] == $past(port.busWdata))
    else $error("Written word with direction bit was not stored.");

  chk_reset_eight: assert property (@(posedge clk) disable iff (!resetn)
    firstCycle_q |-> word_q[0] == RESET_ENTRY_EIGHT)
    else $error("Entry eight reset value wrong.");

  chk_reset_nine: assert property (@(posedge clk) disable iff (!resetn)
    firstCycle_q |-> word_q[1] == RESET_ENTRY_NINE)
    else $error("Entry nine reset value wrong.");

  chk_reset_ten: assert property (@(posedge clk) disable iff (!resetn)
    firstCycle_q |-> word_q[2] == RESET_ENTRY_TEN)
    else $error("Entry ten reset value wrong.");

  chk_reset_eleven: assert property (@(posedge clk) disable iff (!resetn)
    firstCycle_q |-> word_q[3] == RESET_ENTRY_ELEVEN)
    else $error("Entry eleven reset value wrong.");

endmodule

/* verilog/sse_mem_if.sv */
`timescale 1ns/1ps
interface sse_mem_if;
  import sse_pkg::*;

  // Bus port of the entry store.
  logic [SLOT_WIDTH-1:0] busAddr;
  logic                  busWe;
  logic [WORD_WIDTH-1:0] busWdata;
  logic [WORD_WIDTH-1:0] busRdata;

  // Sequencer port of the entry store.
  logic [SLOT_WIDTH-1:0] seqAddr;
  logic [WORD_WIDTH-1:0] seqRdata;

  modport ctrl (output busAddr, busWe, busWdata, seqAddr, input busRdata, seqRdata);
  modport mem  (input busAddr, busWe, busWdata, seqAddr, output busRdata, seqRdata);
endinterface

/* verilog/sse_pkg.sv */
// Behaviour
// - Bit fifteen marks word as read or write.
// - Bits fourteen to nine hold entry select code.
// - Entry nine at 0x29, code 101001b, reset 0x5200.
// - Entry ten at 0x2A, code 101010b, reset 0x5400.
// - Entry eleven at 0x2B, code 101011b, reset 0x5600.
// - Return flag clear: advance after conversion ends.
// - Return flag set: go to first entry.
// - Bits seven to four pick second converter channel.
// - Bits three to zero pick first converter channel.
// - Entry eight at 0x28, code 101000b, reset 0x5000.
package sse_pkg;

  // Word geometry.
  localparam int unsigned ENTRY_COUNT = 4;
  localparam int unsigned WORD_WIDTH  = 16;
  localparam int unsigned BUS_WIDTH   = 32;
  localparam int unsigned ADDR_WIDTH  = 8;
  localparam int unsigned SLOT_WIDTH  = 2;
  localparam int unsigned CHAN_WIDTH  = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] INDEX_ENTRY_EIGHT  = 6'h28;
  localparam logic [5:0] INDEX_ENTRY_NINE   = 6'h29;
  localparam logic [5:0] INDEX_ENTRY_TEN    = 6'h2a;
  localparam logic [5:0] INDEX_ENTRY_ELEVEN = 6'h2b;
  localparam logic [5:0] INDEX_SEQ_STATUS   = 6'h30;

  // Reset values of the entries.
  localparam logic [15:0] RESET_ENTRY_EIGHT  = 16'h5000;
  localparam logic [15:0] RESET_ENTRY_NINE   = 16'h5200;
  localparam logic [15:0] RESET_ENTRY_TEN    = 16'h5400;
  localparam logic [15:0] RESET_ENTRY_ELEVEN = 16'h5600;

  // Field positions inside an entry word.
  localparam int unsigned DIR_BIT = 15;
  localparam int unsigned SEL_MSB = 14;
  localparam int unsigned SEL_LSB = 9;
  localparam int unsigned RET_BIT = 8;
  localparam int unsigned CHB_MSB = 7;
  localparam int unsigned CHB_LSB = 4;
  localparam int unsigned CHA_MSB = 3;
  localparam int unsigned CHA_LSB = 0;

  // Status word field positions.
  localparam int unsigned STAT_SLOT_LSB = 0;
  localparam int unsigned STAT_CHA_LSB  = 4;
  localparam int unsigned STAT_CHB_LSB  = 8;
  localparam int unsigned STAT_BUSY_BIT = 12;

  // Sequencer slots, slot zero being entry eight.
  localparam logic [1:0] FIRST_SLOT = 2'h0;
  localparam logic [1:0] LAST_SLOT  = 2'h3;

  // Bus handshake states.
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_DONE = 3'b100
  } sse_bus_state_e;

  // Select code that belongs to a slot.
  function automatic logic [5:0] sse_slot_code(input logic [1:0] slot);
    sse_slot_code = INDEX_ENTRY_EIGHT | {4'h0, slot};
  endfunction

  // Reset word of a slot.
  function automatic logic [15:0] sse_reset_word(input logic [1:0] slot);
    case (slot)
      2'h0:    sse_reset_word = RESET_ENTRY_EIGHT;
      2'h1:    sse_reset_word = RESET_ENTRY_NINE;
      2'h2:    sse_reset_word = RESET_ENTRY_TEN;
      default: sse_reset_word = RESET_ENTRY_ELEVEN;
    endcase
  endfunction

endpackage

/* verilog/sse_top.sv */
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module sse_top
  import sse_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Avalon-MM slave.
  input  wire logic [ADDR_WIDTH-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [BUS_WIDTH-1:0]  avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [BUS_WIDTH-1:0]  avs_readdata,
  output logic                       avs_waitrequest,
  // Conversion events from the converter engine.
  input  wire logic                  convStart,
  input  wire logic                  convDone,
  // Sequencer outputs.
  output logic      [CHAN_WIDTH-1:0] firstConverterChannel,
  output logic      [CHAN_WIDTH-1:0] secondConverterChannel,
  output logic      [SLOT_WIDTH-1:0] activeSlot,
  output logic                       convBusy
);

  sse_mem_if memIf ();

  sse_bus_state_e        state_q;
  sse_bus_state_e        state_d;
  logic                  waitReq_q;
  logic                  waitReq_d;
  logic [BUS_WIDTH-1:0]  readData_q;
  logic [BUS_WIDTH-1:0]  readData_d;
  logic [SLOT_WIDTH-1:0] activeSlot_q;
  logic [SLOT_WIDTH-1:0] activeSlot_d;
  logic [CHAN_WIDTH-1:0] firstChan_q;
  logic [CHAN_WIDTH-1:0] secondChan_q;
  logic                  convBusy_q;

  // Entry store with one bus port and one sequencer port.
  sse_entry_mem uMem (
    .clk    (clk),
    .resetn (resetn),
    .port   (memIf.mem)
  );

  // Address decode of the request.
  wire logic [5:0]            reqIndex   = avs_address[ADDR_WIDTH-1:2];
  wire logic [SLOT_WIDTH-1:0] reqSlot    = reqIndex[SLOT_WIDTH-1:0];
  wire logic                  reqEntry   = (reqIndex >= INDEX_ENTRY_EIGHT) && (reqIndex <= INDEX_ENTRY_ELEVEN);
  wire logic                  reqStatus  = (reqIndex == INDEX_SEQ_STATUS);
  wire logic                  busReq     = avs_read | avs_write;

  // Byte lanes zero and one merge into the stored word; upper lanes have no bits.
  wire logic [WORD_WIDTH-1:0] oldWord    = memIf.busRdata;
  wire logic [7:0]            mergedHigh = avs_byteenable[1] ? avs_writedata[15:8] : oldWord[15:8];
  wire logic [7:0]            mergedLow  = avs_byteenable[0] ? avs_writedata[7:0] : oldWord[7:0];
  wire logic [WORD_WIDTH-1:0] mergedWord = {mergedHigh, mergedLow};

  // A write is kept only when it carries the entry's own select code.
  wire logic                  selMatch   = mergedWord[SEL_MSB:SEL_LSB] == sse_slot_code(reqSlot);
  wire logic                  entryWe    = (state_q == BUS_DONE) && avs_write && reqEntry && selMatch;

  // Status word shows the sequencer's own state.
  wire logic [BUS_WIDTH-1:0]  statusWord = (BUS_WIDTH'(activeSlot_q) << STAT_SLOT_LSB)
                                         | (BUS_WIDTH'(firstChan_q) << STAT_CHA_LSB)
                                         | (BUS_WIDTH'(secondChan_q) << STAT_CHB_LSB)
                                         | (BUS_WIDTH'(convBusy_q) << STAT_BUSY_BIT);

  // Store connections.
  assign memIf.busAddr  = reqSlot;
  assign memIf.busWe    = entryWe;
  assign memIf.busWdata = mergedWord;
  assign memIf.seqAddr  = activeSlot_d;

  // Handshake: request seen in idle, store answers, then one cycle with waitrequest low.
  always_comb begin
    state_d = state_q;
    case (state_q)
      BUS_IDLE: begin
        if (busReq) begin
          state_d = BUS_RESP;
        end
      end
      BUS_RESP: begin
        state_d = BUS_DONE;
      end
      BUS_DONE: begin
        state_d = BUS_IDLE;
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  // Waitrequest drops only in the cycle of the done state.
  assign waitReq_d = (state_q != BUS_RESP);

  // Read data select; unmapped offsets read as zero.
  always_comb begin
    readData_d = readData_q;
    if (state_q == BUS_RESP) begin
      if (reqEntry) begin
        readData_d = BUS_WIDTH'(memIf.busRdata);
      end else if (reqStatus) begin
        readData_d = statusWord;
      end else begin
        readData_d = '0;
      end
    end
  end

  // Bus registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= BUS_IDLE;
      waitReq_q  <= 1'b1;
      readData_q <= '0;
    end else begin
      state_q    <= state_d;
      waitReq_q  <= waitReq_d;
      readData_q <= readData_d;
    end
  end

  // Fields of the active entry word.
  wire logic [WORD_WIDTH-1:0] seqWord     = memIf.seqRdata;
  wire logic                  returnFlag  = seqWord[RET_BIT];
  wire logic [CHAN_WIDTH-1:0] seqFirstCh  = seqWord[CHA_MSB:CHA_LSB];
  wire logic [CHAN_WIDTH-1:0] seqSecondCh = seqWord[CHB_MSB:CHB_LSB];

  // Next slot after a finished conversion; past entry eleven the walk wraps to entry eight.
  always_comb begin
    activeSlot_d = activeSlot_q;
    if (convDone) begin
      if (returnFlag) begin
        activeSlot_d = FIRST_SLOT;
      end else if (activeSlot_q == LAST_SLOT) begin
        activeSlot_d = FIRST_SLOT;
      end else begin
        activeSlot_d = activeSlot_q + 2'h1;
      end
    end
  end

  // Slot pointer and conversion tracking; a start in the cycle of a done keeps busy set.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activeSlot_q <= FIRST_SLOT;
      convBusy_q   <= 1'b0;
    end else begin
      activeSlot_q <= activeSlot_d;
      convBusy_q   <= convStart | (convBusy_q & ~convDone);
    end
  end

  // Channels are caught at conversion start so later edits wait for the next one.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      firstChan_q  <= '0;
      secondChan_q <= '0;
    end else if (convStart) begin
      firstChan_q  <= seqFirstCh;
      secondChan_q <= seqSecondCh;
    end
  end

  // Outputs straight from registers.
  assign avs_readdata           = readData_q;
  assign avs_waitrequest        = waitReq_q;
  assign firstConverterChannel  = firstChan_q;
  assign secondConverterChannel = secondChan_q;
  assign activeSlot             = activeSlot_q;
  assign convBusy               = convBusy_q;

  // Request taken in idle, answered two cycles later for exactly one cycle.
  sequence reqTaken;
    state_q == BUS_IDLE && busReq;
  endsequence

  sequence answerWindow;
    ##1 avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property busAnswer;
    @(posedge clk) disable iff (!resetn) reqTaken |-> answerWindow;
  endproperty

  chk_bus_answer_timing: assert property (busAnswer)
    else $error("Bus answer not given at the expected cycle.");

  chk_seq_advance: assert property (@(posedge clk) disable iff (!resetn)
    convDone && !returnFlag |=> activeSlot_q == 2'($past(activeSlot_q) + 2'h1))
    else $error("Sequencer did not move to the next entry.");

  chk_seq_return: assert property (@(posedge clk) disable iff (!resetn)
    convDone && returnFlag |=> activeSlot_q == FIRST_SLOT)
    else $error("Sequencer did not return to the first entry.");

  chk_second_chan_latch: assert property (@(posedge clk) disable iff (!resetn)
    convStart |=> secondChan_q == $past(seqSecondCh))
    else $error("Second converter channel not taken from entry.");

  chk_first_chan_latch: assert property (@(posedge clk) disable iff (!resetn)
    convStart |=> firstChan_q == $past(seqFirstCh))
    else $error("First converter channel not taken from entry.");

  chk_chan_hold_midconv: assert property (@(posedge clk) disable iff (!resetn)
    !convStart |=> $stable(firstChan_q) && $stable(secondChan_q))
    else $error("Channel changed without a conversion start.");

  // Answer cycle of the register bus and the cycle that follows it.
  sequence answerCycle;
    state_q == BUS_DONE;
  endsequence

  sequence backToIdle;
    ##1 state_q == BUS_IDLE && avs_waitrequest;
  endsequence

  // A conversion that ends with no new one starting in the same cycle.
  sequence convEndOnly;
    convDone && !convStart;
  endsequence

  // Store answer to an entry request, and to an offset that maps to nothing.
  sequence entryAnswer;
    state_q == BUS_RESP && reqEntry;
  endsequence

  sequence unmappedAnswer;
    state_q == BUS_RESP && !reqEntry && !reqStatus;
  endsequence

  // Waitrequest is low in the answer cycle and in no other.
  chk_wait_only_done: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == BUS_DONE) == !avs_waitrequest)
    else $error("Waitrequest low outside the answer cycle.");

  // After the answer the slave rests idle with waitrequest high again.
  chk_answer_then_idle: assert property (@(posedge clk) disable iff (!resetn)
    answerCycle |-> backToIdle)
    else $error("Bus did not return to idle after the answer.");

  // A request seen in idle moves the handshake on at once.
  chk_take_to_resp: assert property (@(posedge clk) disable iff (!resetn)
    reqTaken |=> state_q == BUS_RESP)
    else $error("Request was not taken in idle.");

  // The store is written only in the answer cycle of a write.
  chk_store_at_answer: assert property (@(posedge clk) disable iff (!resetn)
    memIf.busWe |-> state_q == BUS_DONE && avs_write)
    else $error("Store written outside a write answer.");

  // A write whose select field is not the entry's own code never reaches the store.
  chk_bad_code_dropped: assert property (@(posedge clk) disable iff (!resetn)
    state_q == BUS_DONE && avs_write && !selMatch |-> !memIf.busWe)
    else $error("Write with a foreign select code was stored.");

  // A write to an entry with its own code is always stored.
  chk_good_code_kept: assert property (@(posedge clk) disable iff (!resetn)
    state_q == BUS_DONE && avs_write && reqEntry && selMatch |-> memIf.busWe)
    else $error("Write with the entry's own code was not stored.");

  // Entry reads carry sixteen bits; the upper half of the bus stays zero.
  chk_entry_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
    entryAnswer |=> avs_readdata[BUS_WIDTH-1:WORD_WIDTH] == '0)
    else $error("Entry read drove the upper half of the bus.");

  // Offsets that map to nothing read as zero.
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
    unmappedAnswer |=> avs_readdata == '0)
    else $error("Unmapped read returned a non-zero word.");

  // The status word reports the slot that was active when it was read.
  chk_status_slot: assert property (@(posedge clk) disable iff (!resetn)
    state_q == BUS_RESP && reqStatus |=> avs_readdata[SLOT_WIDTH-1:0] == $past(activeSlot_q))
    else $error("Status word shows the wrong slot.");

  // Read data only change when the store answers.
  chk_readdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    state_q != BUS_RESP |=> $stable(avs_readdata))
    else $error("Read data changed outside an answer.");

  // A conversion start always marks the converter busy.
  chk_busy_set: assert property (@(posedge clk) disable iff (!resetn)
    convStart |=> convBusy)
    else $error("Busy not set by a conversion start.");

  // A finished conversion with no new start clears busy.
  chk_busy_clear: assert property (@(posedge clk) disable iff (!resetn)
    convEndOnly |=> !convBusy)
    else $error("Busy not cleared by a finished conversion.");

  // The active slot moves only when a conversion finishes.
  chk_slot_hold: assert property (@(posedge clk) disable iff (!resetn)
    !convDone |=> $stable(activeSlot_q))
    else $error("Active slot moved without a finished conversion.");

  // Past the last slot the walk wraps to the first one.
  chk_slot_wrap: assert property (@(posedge clk) disable iff (!resetn)
    convDone && activeSlot_q == LAST_SLOT |=> activeSlot_q == FIRST_SLOT)
    else $error("Sequencer did not wrap past the last slot.");

endmodule
